// ==== src/interval_timer_pkg.sv ====
package interval_timer_pkg;
  localparam logic [15:0] ADDR_PORT1_DIRECTION = 16'hff21;
  localparam logic [15:0] ADDR_TIMER_UNIT_MODE = 16'hff6c;
  localparam logic [15:0] ADDR_CARRIER_GATE_CONTROL = 16'hff6d;
  localparam logic [15:0] ADDR_CYCLE_COMPARE = 16'hff70;
  localparam logic [15:0] ADDR_DUTY_COMPARE = 16'hff71;
  localparam logic [15:0] ADDR_PORT1_LATCH = 16'hff72;
  localparam logic [15:0] ADDR_COUNTER = 16'hff73;
  localparam logic [7:0] RST_PORT1_DIRECTION = 8'hff;
  localparam logic [7:0] RST_TIMER_UNIT_MODE = 8'h00;
  localparam logic [7:0] RST_CARRIER_GATE_CONTROL = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'h00;
  localparam logic [7:0] RST_PORT1_LATCH = 8'h00;
  localparam int MODE_ENABLE_BIT = 7;
  localparam int MODE_CKS_HI = 6;
  localparam int MODE_CKS_LO = 4;
  localparam int MODE_MD_HI = 3;
  localparam int MODE_MD_LO = 2;
  localparam int MODE_LEVEL_BIT = 1;
  localparam int MODE_OUT_EN_BIT = 0;
  localparam int CARRIER_REMOTE_BIT = 2;
  localparam int CARRIER_BUFFER_BIT = 1;
  localparam int CARRIER_STATUS_BIT = 0;
  localparam int PIN5 = 5;
  localparam int PIN6 = 6;
  localparam int PRESCALE_WIDTH = 12;
  localparam int SLOW_PRESCALE_WIDTH = 9;
  localparam logic [2:0] CKS_DIV1 = 3'h0;
  localparam logic [2:0] CKS_DIV4 = 3'h1;
  localparam logic [2:0] CKS_DIV16 = 3'h2;
  localparam logic [2:0] CKS_DIV64 = 3'h3;
  localparam logic [2:0] CKS_DIV4096 = 3'h4;
  localparam logic [2:0] CKS_SLOW128 = 3'h5;
  localparam logic [2:0] CKS_SLOW512 = 3'h6;
  localparam logic [2:0] CKS_SLOW1 = 3'h7;
  localparam logic [1:0] MD_INTERVAL = 2'h0;
  localparam logic [1:0] MD_CARRIER = 2'h1;
  localparam logic [1:0] MD_PWM = 2'h2;
  localparam int TRANSFER_DELAY = 2;
endpackage

// ==== src/interval_carrier_timer.sv ====
`timescale 1ns/1ps
module interval_carrier_timer
  import interval_timer_pkg::*;
#(
  parameter int DATA_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] addr,
  input wire logic [DATA_WIDTH-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_WIDTH-1:0] rdata,
  input wire logic low_speed_osc_clock,
  input wire logic synced_companion_interrupt,
  output logic match_interrupt,
  output logic timer_output_pin,
  output logic remote_output_pin,
  output logic [7:0] port1_out,
  output logic [7:0] port1_oe_n
);
  if (DATA_WIDTH != 8) begin : g_width_check
    $error("interval_carrier_timer supports only 8-bit data");
  end

  logic [7:0] mode_q;
  logic [7:0] carrier_q;
  logic [7:0] dir_q;
  logic [7:0] latch_q;
  logic [7:0] cmp0_q;
  logic [7:0] cmp1_q;
  logic [7:0] cmp1_pend_q;
  logic pend_q;
  logic [7:0] cnt_q;
  logic [PRESCALE_WIDTH-1:0] pre_q;
  logic [SLOW_PRESCALE_WIDTH-1:0] slow_q;
  logic lso_q;
  logic started_q;
  logic out_q;
  logic duty_phase_q;
  logic [1:0] xfer_q;
  logic comp_q;
  logic [7:0] rdata_q;
  logic irq_q;
  logic toh_q;
  logic rem_q;

  wire enable = mode_q[MODE_ENABLE_BIT];
  wire [2:0] cks = mode_q[MODE_CKS_HI:MODE_CKS_LO];
  wire [1:0] md = mode_q[MODE_MD_HI:MODE_MD_LO];
  wire level = mode_q[MODE_LEVEL_BIT];
  wire out_en = mode_q[MODE_OUT_EN_BIT];
  wire remote_en = carrier_q[CARRIER_REMOTE_BIT];
  wire gate_buf = carrier_q[CARRIER_BUFFER_BIT];
  wire gate_status = carrier_q[CARRIER_STATUS_BIT];

  // Low-speed oscillator is taken as a synchronous level; its rising edge is one tick.
  wire lso_rise = low_speed_osc_clock & ~lso_q;
  wire [PRESCALE_WIDTH-1:0] pre_next = pre_q + 1'b1;
  wire [SLOW_PRESCALE_WIDTH-1:0] slow_next = slow_q + 1'b1;
  logic tick;
  always_comb begin
    case (cks)
      CKS_DIV1: tick = 1'b1;
      CKS_DIV4: tick = &pre_q[1:0];
      CKS_DIV16: tick = &pre_q[3:0];
      CKS_DIV64: tick = &pre_q[5:0];
      CKS_DIV4096: tick = &pre_q;
      CKS_SLOW128: tick = lso_rise & (&slow_q[6:0]);
      CKS_SLOW512: tick = lso_rise & (&slow_q);
      CKS_SLOW1: tick = lso_rise;
      default: tick = 1'b0;
    endcase
  end

  wire is_interval = (md == MD_INTERVAL);
  wire is_duty_mode = (md == MD_PWM) || (md == MD_CARRIER);
  // The first count clock after enable is masked, so the first match is N+2 ticks away.
  wire cnt_tick = enable & tick & started_q;
  wire match0 = cnt_tick & (cnt_q == cmp0_q) & ~duty_phase_q;
  // Duty compare is never looked at in interval mode.
  wire match1 = cnt_tick & is_duty_mode & duty_phase_q & (cnt_q == cmp1_q);
  wire cycle_end = is_interval ? (cnt_tick & (cnt_q == cmp0_q)) : match0;
  wire [7:0] cnt_inc = cnt_q + 8'h01;

  wire wr_mode = wr & (addr == ADDR_TIMER_UNIT_MODE);
  wire wr_carrier = wr & (addr == ADDR_CARRIER_GATE_CONTROL);
  wire wr_dir = wr & (addr == ADDR_PORT1_DIRECTION);
  wire wr_latch = wr & (addr == ADDR_PORT1_LATCH);
  wire wr_cmp0 = wr & (addr == ADDR_CYCLE_COMPARE);
  wire wr_cmp1 = wr & (addr == ADDR_DUTY_COMPARE);
  wire [7:0] carrier_wr = {5'h00, wdata[CARRIER_REMOTE_BIT], wdata[CARRIER_BUFFER_BIT], gate_status};

  // Bus interface and configuration registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= RST_TIMER_UNIT_MODE;
      dir_q <= RST_PORT1_DIRECTION;
      latch_q <= RST_PORT1_LATCH;
      cmp0_q <= RST_COMPARE;
    end else begin
      if (wr_mode) mode_q <= wdata;
      if (wr_dir) dir_q <= wdata;
      if (wr_latch) latch_q <= wdata;
      if (wr_cmp0) cmp0_q <= wdata;
    end
  end

  // Duty compare: direct write when stopped, otherwise latched until the old value matches; a write in a matching cycle is lost.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp1_q <= RST_COMPARE;
      cmp1_pend_q <= RST_COMPARE;
      pend_q <= 1'b0;
    end else if (wr_cmp1 && !enable) begin
      cmp1_q <= wdata;
      pend_q <= 1'b0;
    end else if (wr_cmp1) begin
      cmp1_pend_q <= wdata;
      pend_q <= ~match1;
    end else if (match1 && pend_q) begin
      cmp1_q <= cmp1_pend_q;
      pend_q <= 1'b0;
    end
  end

  // Prescalers keep running so a selected division is always available.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
      slow_q <= '0;
      lso_q <= 1'b0;
    end else begin
      pre_q <= pre_next;
      lso_q <= low_speed_osc_clock;
      if (lso_rise) slow_q <= slow_next;
    end
  end

  // Counter and output state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      started_q <= 1'b0;
      out_q <= 1'b0;
      duty_phase_q <= 1'b0;
    end else if (!enable) begin
      cnt_q <= 8'h00;
      started_q <= 1'b0;
      out_q <= 1'b0;
      duty_phase_q <= 1'b0;
    end else if (tick && !started_q) begin
      started_q <= 1'b1;
    end else if (cycle_end) begin
      cnt_q <= 8'h00;
      out_q <= ~out_q;
      duty_phase_q <= is_duty_mode;
    end else if (match1) begin
      cnt_q <= cnt_inc;
      out_q <= ~out_q;
      duty_phase_q <= 1'b0;
    end else if (cnt_tick) begin
      cnt_q <= cnt_inc;
    end
  end

  // Gate status follows the buffer two count clocks after the companion interrupt rises.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      carrier_q <= RST_CARRIER_GATE_CONTROL;
      comp_q <= 1'b0;
      xfer_q <= 2'b00;
    end else begin
      if (wr_carrier) carrier_q <= carrier_wr;
      if (tick) begin
        comp_q <= synced_companion_interrupt;
        xfer_q <= {xfer_q[0], synced_companion_interrupt & ~comp_q};
        if (xfer_q[TRANSFER_DELAY-1]) carrier_q[CARRIER_STATUS_BIT] <= gate_buf;
      end
    end
  end

  // Output pins: disabled output shows the default level, toggled state XORs it.
  wire toh_d = out_en ? (level ^ out_q) : level;
  wire carrier_d = is_interval ? 1'b0 : toh_d;
  wire rem_d = remote_en ? (gate_status & gate_buf & carrier_d) : gate_buf;

  logic [7:0] rdata_d;
  always_comb begin
    case (addr)
      ADDR_TIMER_UNIT_MODE: rdata_d = mode_q;
      ADDR_CARRIER_GATE_CONTROL: rdata_d = carrier_q;
      ADDR_PORT1_DIRECTION: rdata_d = dir_q;
      ADDR_PORT1_LATCH: rdata_d = latch_q;
      ADDR_CYCLE_COMPARE: rdata_d = cmp0_q;
      ADDR_DUTY_COMPARE: rdata_d = pend_q ? cmp1_pend_q : cmp1_q;
      ADDR_COUNTER: rdata_d = cnt_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      toh_q <= 1'b0;
      rem_q <= 1'b0;
    end else begin
      rdata_q <= rd ? rdata_d : 8'h00;
      irq_q <= cycle_end;
      toh_q <= toh_d;
      rem_q <= rem_d;
    end
  end

  // Direction 0 drives the pin; timer outputs are ORed with the latch on pins 5 and 6.
  logic [7:0] pout_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pout_q <= 8'h00;
    end else begin
      pout_q <= latch_q;
      pout_q[PIN5] <= latch_q[PIN5] | toh_d;
      pout_q[PIN6] <= latch_q[PIN6] | rem_d;
    end
  end

  logic [7:0] oe_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) oe_q <= RST_PORT1_DIRECTION;
    else oe_q <= dir_q;
  end

  assign rdata = rdata_q;
  assign match_interrupt = irq_q;
  assign timer_output_pin = toh_q;
  assign remote_output_pin = rem_q;
  assign port1_out = pout_q;
  assign port1_oe_n = oe_q;

  interval_match_a: assert property (@(posedge clk) disable iff (rst)
    (enable && is_interval && cnt_tick && cnt_q == cmp0_q) |=> match_interrupt && cnt_q == 8'h00)
    else $error("interval match did not interrupt and clear");
  stop_clears_a: assert property (@(posedge clk) disable iff (rst)
    !enable |=> cnt_q == 8'h00 ##1 !match_interrupt)
    else $error("stopped timer not cleared");
  stop_default_a: assert property (@(posedge clk) disable iff (rst)
    !enable ##1 !enable |=> timer_output_pin == $past(level))
    else $error("timer output not at default when stopped");
  square_toggle_a: assert property (@(posedge clk) disable iff (rst)
    (is_interval && out_en && cycle_end && $stable(mode_q)) |=> out_q != $past(out_q))
    else $error("output did not toggle on match");
  count_step_a: assert property (@(posedge clk) disable iff (rst)
    (cnt_tick && !cycle_end && !match1) |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("counter did not step by one");
  duty_ignored_a: assert property (@(posedge clk) disable iff (rst)
    (is_interval && cnt_tick && cnt_q == cmp1_q && cnt_q != cmp0_q) |=>
    !match_interrupt && cnt_q == $past(cnt_q) + 8'h01)
    else $error("duty match in interval mode");
  remote_pin_a: assert property (@(posedge clk) disable iff (rst)
    !remote_en |=> remote_output_pin == $past(gate_buf))
    else $error("remote pin wrong");
  status_ro_a: assert property (@(posedge clk) disable iff (rst)
    (wr_carrier && !(tick && xfer_q[1])) |=> gate_status == $past(gate_status))
    else $error("status bit written by software");
endmodule

// ==== test/load_model.sv ====
`timescale 1ns/1ps
module load_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic drive,
  input wire logic oe_n,
  output logic pin,
  output int edges
);
  logic last_q;
  // A released pin falls to the load's pull-down, so a stale level never passes for output.
  assign pin = oe_n ? 1'b0 : drive;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q <= 1'b0;
      edges <= 0;
    end else begin
      last_q <= pin;
      if (pin !== last_q) edges <= edges + 1;
    end
  end
endmodule

// ==== test/eight_bit_interval_carrier_timer_tb.sv ====
`timescale 1ns/1ps
module eight_bit_interval_carrier_timer_tb;
  import interval_timer_pkg::*;
  logic clk, rst, wr, rd, comp, irq, tout, rout, pin;
  logic osc = 1'b0;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, port1_out, port1_oe_n, d, v;
  int fails = 0, checks = 0, seed = 32'h32de, edges, n, e0, oc = 0;
  interval_carrier_timer uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .low_speed_osc_clock(osc), .synced_companion_interrupt(comp), .match_interrupt(irq),
    .timer_output_pin(tout), .remote_output_pin(rout), .port1_out(port1_out), .port1_oe_n(port1_oe_n));
  load_model load (.clk(clk), .rst(rst), .drive(port1_out[PIN5]), .oe_n(port1_oe_n[PIN5]), .pin(pin),
    .edges(edges));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // The slow oscillator runs at one sixth of clk, unrelated to any prescaler phase.
  always @(posedge clk) begin
    oc <= (oc == 2) ? 0 : oc + 1;
    if (oc == 2) osc <= ~osc;
  end
  task automatic test_done();
    $display("Counts: checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic chk1(input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_int(input int e, input int g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [15:0] a, output logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 x = rdata;
  endtask
  function automatic int period(input logic [2:0] c, input int m);
    int div[8] = '{1, 4, 16, 64, 4096, 768, 3072, 6};
    return (m + 1) * div[c];
  endfunction
  task automatic measure(input int exp, input int ne);
    int k;
    k = 0;
    #1;
    while (irq !== 1'b1) begin
      @(posedge clk);
      #1 k++;
      if (k > 30000) begin
        fails++;
        $display("Error at %0t: expected %h got %h", $time, exp, k);
        test_done();
      end
    end
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
      if (k == 2) e0 = edges;
      if (k > 30000) begin
        fails++;
        $display("Error at %0t: expected %h got %h", $time, exp, k);
        test_done();
      end
    end while (irq !== 1'b1);
    chk_int(exp, k);
    repeat (2) @(posedge clk);
    #1 chk_int(ne, edges - e0);
  endtask
  task automatic carrier(input logic [7:0] x, input logic [7:0] er, input logic eo);
    wreg(ADDR_CARRIER_GATE_CONTROL, x);
    comp <= 1'b1;
    repeat (3) @(posedge clk);
    comp <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk1(eo, rout);
    rreg(ADDR_CARRIER_GATE_CONTROL, d);
    chk8(er, d);
  endtask
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    comp = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rreg(ADDR_PORT1_DIRECTION, d);
    chk8(RST_PORT1_DIRECTION, d);
    rreg(ADDR_TIMER_UNIT_MODE, d);
    chk8(RST_TIMER_UNIT_MODE, d);
    rreg(ADDR_CARRIER_GATE_CONTROL, d);
    chk8(RST_CARRIER_GATE_CONTROL, d);
    rreg(16'hff00, d);
    chk8(8'h00, d);
    $display("Test reset done");
    v = 8'($random(seed));
    wreg(ADDR_PORT1_DIRECTION, v);
    rreg(ADDR_PORT1_DIRECTION, d);
    chk8(v, d);
    chk8(v, port1_oe_n);
    wreg(ADDR_PORT1_DIRECTION, 8'h9f);
    wreg(ADDR_PORT1_LATCH, 8'h00);
    $display("Test port done");
    for (int c = 0; c < 8; c++) begin
      n = (c >= 4) ? 2 : 2 + ($unsigned($random(seed)) % 8);
      v = {1'b0, c[2:0], MD_INTERVAL, 2'b01};
      wreg(ADDR_TIMER_UNIT_MODE, v);
      wreg(ADDR_CYCLE_COMPARE, n[7:0]);
      d = 8'($unsigned($random(seed)) % n);
      wreg(ADDR_DUTY_COMPARE, d);
      wreg(ADDR_TIMER_UNIT_MODE, v | 8'h80);
      measure(period(c[2:0], n), 1);
      wreg(ADDR_TIMER_UNIT_MODE, v);
      repeat (2) @(posedge clk);
      #1 chk1(1'b0, tout);
      chk1(1'b0, irq);
      rreg(ADDR_COUNTER, d);
      chk8(8'h00, d);
    end
    wreg(ADDR_TIMER_UNIT_MODE, 8'h03);
    repeat (2) @(posedge clk);
    #1 chk1(1'b1, tout);
    chk1(1'b1, pin);
    $display("Test interval done");
    wreg(ADDR_CARRIER_GATE_CONTROL, 8'hf9);
    rreg(ADDR_CARRIER_GATE_CONTROL, d);
    chk8(8'h00, d);
    wreg(ADDR_TIMER_UNIT_MODE, 8'h00);
    wreg(ADDR_CYCLE_COMPARE, 8'h10);
    wreg(ADDR_TIMER_UNIT_MODE, 8'h80);
    carrier(8'h02, 8'h03, 1'b1);
    carrier(8'h04, 8'h04, 1'b0);
    carrier(8'h00, 8'h00, 1'b0);
    carrier(8'h06, 8'h07, 1'b0);
    $display("Test carrier done");
    wreg(ADDR_TIMER_UNIT_MODE, 8'h00);
    // Both compares toggle the output in these modes, so one period shows two edges.
    for (int m = 1; m < 3; m++) begin
      v = {1'b0, CKS_DIV1, m[1:0], 2'b01};
      wreg(ADDR_TIMER_UNIT_MODE, v);
      wreg(ADDR_CYCLE_COMPARE, 8'h06);
      wreg(ADDR_DUTY_COMPARE, 8'h02);
      wreg(ADDR_TIMER_UNIT_MODE, v | 8'h80);
      measure(period(CKS_DIV1, 6), 2);
      repeat (7) begin
        @(posedge clk);
        #1 chk1(tout, rout);
      end
      wreg(ADDR_TIMER_UNIT_MODE, v);
      repeat (2) @(posedge clk);
      #1 chk1(1'b0, tout);
    end
    $display("Test duty modes done");
    test_done();
  end
endmodule
